// >>> rft_params.svh
`ifndef RFT_PARAMS_SVH
`define RFT_PARAMS_SVH

// register indices; byte address is four times the index
`define RFT_IDX_T2_CONTROL 6'h19
`define RFT_IDX_T2_RELOAD_HIGH 6'h1a
`define RFT_IDX_T2_RELOAD_LOW 6'h1b
`define RFT_IDX_T2_COUNT_HIGH 6'h1c
`define RFT_IDX_T2_COUNT_LOW 6'h1d
`define RFT_IDX_T3_CONTROL 6'h1e
`define RFT_IDX_T3_RELOAD_HIGH 6'h1f
`define RFT_IDX_T3_RELOAD_LOW 6'h20
`define RFT_IDX_T3_COUNT_HIGH 6'h21
`define RFT_IDX_T3_COUNT_LOW 6'h22
`define RFT_IDX_STATUS 6'h30

// control field positions
`define RFT_BIT_STOP_RX 7
`define RFT_BIT_START_LO 4
`define RFT_BIT_RELOAD_ON_ZERO 3
`define RFT_BIT_CLOCK_LO 0
`define RFT_CONTROL_WMASK 8'hbb

// status field positions
`define RFT_BIT_FLAG_LO 0
`define RFT_BIT_RUNNING_LO 4

// reset values
`define RFT_CONTROL_RESET 8'h00
`define RFT_RELOAD_RESET 16'h0000
`define RFT_FLAGS_RESET 2'h0

`endif

// >>> rft_pkg.sv
package rft_pkg;

    typedef enum logic [1:0] {
        RFT_START_NONE,
        RFT_START_TXEND,
        RFT_START_TRIM,
        RFT_START_TRIM_UF
    } rft_start_mode_t;

    typedef enum logic [1:0] {
        RFT_CLK_13M56,
        RFT_CLK_212K,
        RFT_CLK_TIMER0,
        RFT_CLK_TIMER1
    } rft_clock_sel_t;

    typedef struct packed {
        logic stopOnRx;
        logic rsvd6;
        rft_start_mode_t startMode;
        logic reloadOnZero;
        logic rsvd2;
        rft_clock_sel_t clockSelect;
    } rft_control_t;

    typedef struct packed {
        logic tick13m56;
        logic tick212k;
        logic timer0Underflow;
        logic timer1Underflow;
    } rft_tick_src_t;

    typedef struct packed {
        logic txEnd;
        logic rxFirstBits;
        logic trimRise;
    } rft_rf_events_t;

endpackage

// >>> rft_countdown.sv
`timescale 1ns/1ns
`include "rft_params.svh"
module rft_countdown (
    input wire logic core_clk,
    input wire logic rstN,
    input wire rft_pkg::rft_control_t control,
    input wire logic [15:0] reload,
    input wire rft_pkg::rft_rf_events_t events,
    input wire logic tick,
    output logic [15:0] count,
    output logic running,
    output logic underflow
);
    import rft_pkg::*;

    logic trimMode;
    logic startEvent;
    logic stopEvent;
    logic countStep;
    logic atZero;
    logic restartAtZero;

    assign trimMode = control.startMode[1];
    assign startEvent = ((control.startMode == RFT_START_TXEND) && events.txEnd)
        || (trimMode && events.trimRise && !running);
    // stop on rx only outside trimming; a trim edge toggles
    assign stopEvent = running && ((trimMode && events.trimRise)
        || (!trimMode && control.stopOnRx && events.rxFirstBits));
    assign countStep = running && tick && !startEvent && !stopEvent;
    assign atZero = (count == 16'h0000);
    // trimming without underflow always halts at zero
    assign restartAtZero = control.reloadOnZero && (control.startMode != RFT_START_TRIM);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            running <= 1'b0;
        end else if (startEvent) begin
            running <= 1'b1;
        end else if (stopEvent) begin
            running <= 1'b0;
        end else if (countStep && atZero && !restartAtZero) begin
            running <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            count <= `RFT_RELOAD_RESET;
        end else if (startEvent) begin
            count <= reload;
        end else if (countStep) begin
            if (!atZero) begin
                count <= count - 16'h0001;
            end else if (restartAtZero) begin
                count <= reload;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            underflow <= 1'b0;
        end else begin
            underflow <= countStep && atZero && (control.startMode != RFT_START_TRIM);
        end
    end

endmodule

// >>> rft_timer23.sv
`timescale 1ns/1ns
`include "rft_params.svh"
module rft_timer23 (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic txEnd,
    input wire logic rxFirstBits,
    input wire logic lfoTrimPin,
    input wire rft_pkg::rft_tick_src_t tickSrc,
    output logic [1:0] underflowFlags,
    output logic [1:0] timerRunning
);
    import rft_pkg::*;

    localparam int NUM_TIMERS = 2;

    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisation

    logic rstSync1;
    logic rstSync2;
    logic rstN;
    logic trimSync1;
    logic trimSync2;
    logic trimLast;
    logic trimRise;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    assign rstN = rstSync2;

    // oscillator pin is asynchronous; only the second stage and its delayed copy are looked at
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            trimSync1 <= 1'b0;
            trimSync2 <= 1'b0;
            trimLast <= 1'b0;
        end else begin
            trimSync1 <= lfoTrimPin;
            trimSync2 <= trimSync1;
            trimLast <= trimSync2;
        end
    end

    assign trimRise = trimSync2 && !trimLast;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstN);

    ////////////////////////////////////////////////////////////////////////
    // shared decoding

    function automatic logic [5:0] regIndex(input logic [7:0] addr);
        regIndex = addr[7:2];
    endfunction

    function automatic logic selectTick(input rft_clock_sel_t sel,
                                        input rft_tick_src_t src);
        unique case (sel)
            RFT_CLK_13M56: selectTick = src.tick13m56;
            RFT_CLK_212K: selectTick = src.tick212k;
            RFT_CLK_TIMER0: selectTick = src.timer0Underflow;
            RFT_CLK_TIMER1: selectTick = src.timer1Underflow;
        endcase
    endfunction

    function automatic rft_control_t maskControl(input logic [7:0] data);
        maskControl = rft_control_t'(data & `RFT_CONTROL_WMASK);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // avalon slave handshake: one wait cycle per access

    logic ack;
    logic request;
    logic wrStrobe;
    logic [5:0] index;
    logic [7:0] next_readByte;

    assign request = avs_read || avs_write;
    assign avs_waitrequest = request && !ack;
    assign wrStrobe = avs_write && ack && avs_byteenable[0];
    assign index = regIndex(avs_address);

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ack <= 1'b0;
        end else begin
            ack <= request && !ack;
        end
    end

    AST_WAIT_ONE: assert property (
        request && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");

    ////////////////////////////////////////////////////////////////////////
    // software registers

    rft_control_t control [NUM_TIMERS];
    logic [15:0] reload [NUM_TIMERS];
    logic [15:0] count [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] running;
    logic [NUM_TIMERS-1:0] underflow;
    logic [NUM_TIMERS-1:0] flags;
    logic [NUM_TIMERS-1:0] flagClear;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            control[0] <= rft_control_t'(`RFT_CONTROL_RESET);
            control[1] <= rft_control_t'(`RFT_CONTROL_RESET);
        end else if (wrStrobe) begin
            if (index == `RFT_IDX_T2_CONTROL) begin
                control[0] <= maskControl(avs_writedata[7:0]);
            end
            if (index == `RFT_IDX_T3_CONTROL) begin
                control[1] <= maskControl(avs_writedata[7:0]);
            end
        end
    end

    AST_T3_CONTROL_WRITE: assert property (
        wrStrobe && index == `RFT_IDX_T3_CONTROL
        |=> 8'(control[1]) == ($past(avs_writedata[7:0]) & `RFT_CONTROL_WMASK))
        else $error("timer 3 control write not stored masked");

    // reload feeds the counter on a start event and on a restart at zero
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            reload[0] <= `RFT_RELOAD_RESET;
            reload[1] <= `RFT_RELOAD_RESET;
        end else if (wrStrobe) begin
            unique case (index)
                `RFT_IDX_T2_RELOAD_HIGH: reload[0][15:8] <= avs_writedata[7:0];
                `RFT_IDX_T2_RELOAD_LOW: reload[0][7:0] <= avs_writedata[7:0];
                `RFT_IDX_T3_RELOAD_HIGH: reload[1][15:8] <= avs_writedata[7:0];
                `RFT_IDX_T3_RELOAD_LOW: reload[1][7:0] <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    AST_RELOAD_WRITE: assert property (
        wrStrobe && index == `RFT_IDX_T2_RELOAD_LOW
        |=> reload[0][7:0] == $past(avs_writedata[7:0]))
        else $error("timer 2 reload low byte not stored");

    assign flagClear = (wrStrobe && index == `RFT_IDX_STATUS) ?
        avs_writedata[`RFT_BIT_FLAG_LO +: NUM_TIMERS] : '0;

    // a new underflow in the clearing cycle survives the clear
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            flags <= `RFT_FLAGS_RESET;
        end else begin
            flags <= (flags & ~flagClear) | underflow;
        end
    end

    AST_FLAG_CLEAR: assert property (
        flagClear[0] && !underflow[0] |=> !flags[0])
        else $error("timer 2 flag not cleared by write");

    assign underflowFlags = flags;
    assign timerRunning = running;

    ////////////////////////////////////////////////////////////////////////
    // read path; count bytes are live and not latched as a pair,
    // so reading both halves while counting can tear

    always_comb begin
        next_readByte = 8'h00;
        unique case (index)
            `RFT_IDX_T2_CONTROL: next_readByte = control[0];
            `RFT_IDX_T2_RELOAD_HIGH: next_readByte = reload[0][15:8];
            `RFT_IDX_T2_RELOAD_LOW: next_readByte = reload[0][7:0];
            `RFT_IDX_T2_COUNT_HIGH: next_readByte = count[0][15:8];
            `RFT_IDX_T2_COUNT_LOW: next_readByte = count[0][7:0];
            `RFT_IDX_T3_CONTROL: next_readByte = control[1];
            `RFT_IDX_T3_RELOAD_HIGH: next_readByte = reload[1][15:8];
            `RFT_IDX_T3_RELOAD_LOW: next_readByte = reload[1][7:0];
            `RFT_IDX_T3_COUNT_HIGH: next_readByte = count[1][15:8];
            `RFT_IDX_T3_COUNT_LOW: next_readByte = count[1][7:0];
            `RFT_IDX_STATUS: begin
                next_readByte[`RFT_BIT_FLAG_LO +: NUM_TIMERS] = flags;
                next_readByte[`RFT_BIT_RUNNING_LO +: NUM_TIMERS] = running;
            end
            default: next_readByte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack) begin
            avs_readdata <= {24'h000000, next_readByte};
        end
    end

    AST_READ_RELOAD: assert property (
        avs_read && !ack && index == `RFT_IDX_T2_RELOAD_HIGH
        |=> avs_readdata == {24'h000000, $past(reload[0][15:8])})
        else $error("reload high read data wrong");

    // count is sampled on the edge that ends the wait cycle, so the read shows the wait cycle's value
    AST_READ_COUNT: assert property (
        avs_read && !ack && index == `RFT_IDX_T2_COUNT_LOW
        |=> avs_readdata == {24'h000000, $past(count[0][7:0])})
        else $error("count low read data wrong");

    ////////////////////////////////////////////////////////////////////////
    // the two timers; index 0 is timer 2, index 1 is timer 3

    rft_rf_events_t events;

    assign events = '{txEnd: txEnd, rxFirstBits: rxFirstBits, trimRise: trimRise};

    genvar t;
    generate
        for (t = 0; t < NUM_TIMERS; t++) begin : gTimer
            logic tick;
            logic trimMode;
            logic quiet;

            assign tick = selectTick(control[t].clockSelect, tickSrc);
            assign trimMode = control[t].startMode[1];
            assign quiet = !txEnd && !rxFirstBits && !trimRise;

            rft_countdown uCountdown (
                .core_clk(core_clk),
                .rstN(rstN),
                .control(control[t]),
                .reload(reload[t]),
                .events(events),
                .tick(tick),
                .count(count[t]),
                .running(running[t]),
                .underflow(underflow[t])
            );

            AST_NO_AUTO: assert property (
                !running[t] && control[t].startMode == RFT_START_NONE
                && !wrStrobe |=> !running[t])
                else $error("timer started with start mode none");

            AST_TX_START: assert property (
                txEnd && control[t].startMode == RFT_START_TXEND
                |=> running[t] && count[t] == $past(reload[t]))
                else $error("end of transmission did not load reload value");

            AST_TRIM_STOP: assert property (
                running[t] && trimMode && trimRise |=> !running[t])
                else $error("trim edge did not stop running timer");

            AST_TRIM_START: assert property (
                !running[t] && trimMode && trimRise
                |=> running[t] && count[t] == $past(reload[t]))
                else $error("trim edge did not start timer");

            AST_DECREMENT: assert property (
                running[t] && tick && quiet && count[t] != 16'h0000
                |=> count[t] == $past(count[t]) - 16'h0001 && running[t])
                else $error("count did not decrement on selected tick");

            AST_HOLD_NO_TICK: assert property (
                running[t] && !tick && quiet |=> $stable(count[t]))
                else $error("count moved without a tick");

            AST_RESTART: assert property (
                running[t] && tick && quiet && count[t] == 16'h0000
                && control[t].reloadOnZero
                && control[t].startMode != RFT_START_TRIM
                |=> running[t] && count[t] == $past(reload[t])
                ##1 flags[t])
                else $error("no reload or flag after zero with restart");

            AST_STOP_AT_ZERO: assert property (
                running[t] && tick && quiet && count[t] == 16'h0000
                && !control[t].reloadOnZero |=> !running[t])
                else $error("timer kept running past zero");

            AST_UNDERFLOW_FLAG: assert property (
                underflow[t] |=> flags[t])
                else $error("underflow did not set flag");

            AST_NO_UF_TRIM: assert property (
                underflow[t] |-> $past(control[t].startMode) != RFT_START_TRIM)
                else $error("underflow in trimming mode without underflow");

            AST_STOP_RX: assert property (
                running[t] && rxFirstBits && control[t].stopOnRx
                && !trimMode && !txEnd |=> !running[t])
                else $error("stop on receive did not stop timer");

            AST_RX_TRIM_IGNORED: assert property (
                running[t] && rxFirstBits && trimMode && !trimRise
                && !(tick && count[t] == 16'h0000)
                |=> running[t])
                else $error("receive stopped a trimming timer");

            AST_RESERVED_ZERO: assert property (
                control[t].rsvd6 == 1'b0 && control[t].rsvd2 == 1'b0)
                else $error("reserved control bit set");
        end
    endgenerate

    AST_FLAG_STICKY: assert property (
        flags[1] && !flagClear[1] |=> flags[1])
        else $error("timer 3 flag dropped without a clear");

endmodule

// >>> tb_rf_frontend_timer2_timer3.sv
`timescale 1ns/1ns
`include "rft_params.svh"
module tb_rf_frontend_timer2_timer3;
import rft_pkg::*;

logic core_clk;
logic nrst;
logic [7:0] avs_address;
logic avs_read;
logic avs_write;
logic [31:0] avs_writedata;
logic [3:0] avs_byteenable;
logic [31:0] avs_readdata;
logic avs_waitrequest;
logic txEnd;
logic rxFirstBits;
logic lfoTrimPin;
rft_tick_src_t tickSrc;
logic [1:0] underflowFlags;
logic [1:0] timerRunning;
int n_mismatch;
int n_compared;
int seed;
logic [31:0] rdat;
logic [15:0] rel;

rft_timer23 dut_u (
    .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txEnd(txEnd),
    .rxFirstBits(rxFirstBits), .lfoTrimPin(lfoTrimPin), .tickSrc(tickSrc),
    .underflowFlags(underflowFlags), .timerRunning(timerRunning)
);

initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
end

////////////////////////////////////////////////////////////////////////////////
task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask

// a hung wait counts as one mismatch and ends the run
task automatic to_fail();
    check(32'h0, 32'h1);
    stop_test();
endtask

task automatic endt(input string nm);
    $display("test %s done", nm);
endtask

function automatic logic [5:0] base(input int t);
    return (t == 0) ? `RFT_IDX_T2_CONTROL : `RFT_IDX_T3_CONTROL;
endfunction

function automatic logic [7:0] ctl(input logic sr, input logic [1:0] m, input logic rz,
                                   input logic [1:0] c);
    return {sr, 1'b0, m, rz, 1'b0, c};
endfunction

////////////////////////////////////////////////////////////////////////////////
// request held until waitrequest is seen low at a rising edge
task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                   input logic [3:0] be);
    int i;
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'($random(seed)), d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    for (i = 0; i < 16; i++) begin
        @(posedge core_clk);
        if (avs_waitrequest === 1'b0) break;
    end
    if (i == 16) to_fail();
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
endtask

task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf);
endtask

task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 4'hf);
    check(rdat, {24'h0, e});
endtask

// count bytes are live; callers keep reads clear of tick pulses
task automatic chkcnt(input int t, input logic [15:0] e);
    rdchk(base(t) + 6'd3, e[15:8]);
    rdchk(base(t) + 6'd4, e[7:0]);
endtask

task automatic cfg(input int t, input logic [7:0] c, input logic [15:0] r);
    wr(base(t), c);
    wr(base(t) + 6'd1, r[15:8]);
    wr(base(t) + 6'd2, r[7:0]);
endtask

task automatic ev(input logic [1:0] e);
    @(posedge core_clk);
    {txEnd, rxFirstBits} <= e;
    @(posedge core_clk);
    {txEnd, rxFirstBits} <= 2'b00;
    @(negedge core_clk);
endtask

task automatic ticks(input logic [3:0] src, input int n);
    repeat (n) begin
        @(posedge core_clk);
        tickSrc <= src;
        @(posedge core_clk);
        tickSrc <= 4'h0;
    end
    @(negedge core_clk);
endtask

// pin passes a two-flop synchroniser, so the running bit is polled
task automatic trim(input int t);
    logic was;
    int i;
    was = timerRunning[t];
    @(posedge core_clk);
    lfoTrimPin <= 1'b1;
    for (i = 0; i < 12; i++) begin
        @(negedge core_clk);
        if (timerRunning[t] !== was) break;
    end
    if (i == 12) to_fail();
    @(posedge core_clk);
    lfoTrimPin <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (100000) @(posedge core_clk);
    to_fail();
end

initial begin
    int t;
    int s;
    int k;
    logic [7:0] d;
    logic [3:0] sel;
    seed = 32'h4874;
    n_mismatch = 0;
    n_compared = 0;
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    txEnd = 1'b0;
    rxFirstBits = 1'b0;
    lfoTrimPin = 1'b0;
    tickSrc = 4'h0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (t = 0; t < 2; t++) begin
        for (k = 0; k < 5; k++) begin
            rdchk(base(t) + 6'(k), 8'h00);
        end
        for (k = 0; k < 6; k++) begin
            d = 8'($random(seed));
            wr(base(t), d);
            rdchk(base(t), d & 8'hbb);
            wr(base(t) + 6'd1, ~d);
            rdchk(base(t) + 6'd1, ~d);
        end
        bus(1'b1, base(t) + 6'd2, 8'h5a, 4'he);
        rdchk(base(t) + 6'd2, 8'h00);
        wr(base(t) + 6'd3, 8'h77);
        rdchk(base(t) + 6'd3, 8'h00);
        // a random mode left behind would let later tx ends start this timer
        wr(base(t), 8'h00);
    end
    wr(6'h3f, 8'hff);
    rdchk(6'h3f, 8'h00);
    endt("registers");
    for (t = 0; t < 2; t++) begin
        cfg(t, ctl(1'b0, 2'b00, 1'b0, 2'b00), 16'h0005);
        ev(2'b10);
        check(32'(timerRunning[t]), 32'd0);
        rel = 16'(2 + ($random(seed) & 7));
        cfg(t, ctl(1'b0, 2'b01, 1'b0, 2'b00), rel);
        ev(2'b10);
        check(32'(timerRunning[t]), 32'd1);
        rdchk(`RFT_IDX_STATUS, 8'h10 << t);
        chkcnt(t, rel);
        ticks(4'h8, int'(rel));
        chkcnt(t, 16'h0000);
        ticks(4'h8, 1);
        repeat (3) @(posedge core_clk);
        check(32'(timerRunning[t]), 32'd0);
        check(32'(underflowFlags[t]), 32'd1);
        check(32'(underflowFlags[1 - t]), 32'd0);
        rdchk(`RFT_IDX_STATUS, 8'h01 << t);
        wr(`RFT_IDX_STATUS, 8'h03);
        @(negedge core_clk);
        check(32'(underflowFlags), 32'd0);
        // park the timer so the other timer's tx end cannot restart it
        wr(base(t), 8'h00);
    end
    endt("one shot");
    for (t = 0; t < 2; t++) begin
        cfg(t, ctl(1'b0, 2'b01, 1'b1, 2'b00), 16'h0003);
        ev(2'b10);
        ticks(4'h8, 4);
        chkcnt(t, 16'h0003);
        check(32'(timerRunning[t]), 32'd1);
        check(32'(underflowFlags[t]), 32'd1);
        ticks(4'h8, 1);
        wr(base(t) + 6'd2, 8'h09);
        chkcnt(t, 16'h0002);
        ev(2'b10);
        chkcnt(t, 16'h0009);
        wr(`RFT_IDX_STATUS, 8'h03);
    end
    endt("restart");
    for (t = 0; t < 2; t++) begin
        for (s = 0; s < 4; s++) begin
            sel = 4'h8 >> s;
            cfg(t, ctl(1'b0, 2'b01, 1'b0, 2'(s)), 16'h1000);
            ev(2'b10);
            ticks(~sel, 2);
            chkcnt(t, 16'h1000);
            ticks(sel, 1);
            chkcnt(t, 16'h0fff);
        end
    end
    endt("clock select");
    for (t = 0; t < 2; t++) begin
        cfg(t, ctl(1'b1, 2'b01, 1'b0, 2'b00), 16'h0100);
        ev(2'b10);
        ticks(4'h8, 1);
        ev(2'b01);
        check(32'(timerRunning[t]), 32'd0);
        ticks(4'h8, 1);
        chkcnt(t, 16'h00ff);
        cfg(t, ctl(1'b0, 2'b01, 1'b0, 2'b00), 16'h0001);
        ev(2'b10);
        ev(2'b01);
        check(32'(timerRunning[t]), 32'd1);
        ticks(4'h8, 2);
        check(32'(timerRunning[t]), 32'd0);
    end
    endt("stop on receive");
    wr(`RFT_IDX_STATUS, 8'h03);
    for (t = 0; t < 2; t++) begin
        cfg(t, ctl(1'b1, 2'b11, 1'b0, 2'b00), 16'h0001);
        trim(t);
        check(32'(timerRunning[t]), 32'd1);
        chkcnt(t, 16'h0001);
        ev(2'b01);
        check(32'(timerRunning[t]), 32'd1);
        trim(t);
        check(32'(timerRunning[t]), 32'd0);
        trim(t);
        ticks(4'h8, 2);
        repeat (3) @(posedge core_clk);
        check(32'(underflowFlags[t]), 32'd1);
        wr(`RFT_IDX_STATUS, 8'h03);
        // mode 10 must reach zero without raising the flag
        cfg(t, ctl(1'b0, 2'b10, 1'b0, 2'b00), 16'h0001);
        trim(t);
        ticks(4'h8, 2);
        repeat (3) @(posedge core_clk);
        check(32'(underflowFlags[t]), 32'd0);
        chkcnt(t, 16'h0000);
    end
    endt("trimming");
    stop_test();
end

endmodule
